// ---- include/pmi_pkg.sv ----
// pmi_pkg: shared constants and types of the power monitor serial slave.
// assumes a 100 MHz system clock and a two-wire bus sampled by that clock.
package pmi_pkg;

    // register pointer values
    localparam logic [7:0]  PMI_REG_CONFIG  = 8'h00;
    localparam logic [7:0]  PMI_REG_SHUNT   = 8'h01;
    localparam logic [7:0]  PMI_REG_BUS     = 8'h02;
    localparam logic [7:0]  PMI_REG_POWER   = 8'h03;
    localparam logic [7:0]  PMI_REG_CURRENT = 8'h04;
    localparam logic [7:0]  PMI_REG_CAL     = 8'h05;

    // reset values
    localparam logic [15:0] PMI_CFG_RESET   = 16'h4127;
    localparam logic [15:0] PMI_ZERO16      = 16'h0000;

    // fixed upper address bits (100) and byte framing
    localparam logic [2:0]  PMI_ADDR_FIXED  = 3'h4;
    localparam logic [3:0]  PMI_BYTE_BITS   = 4'h8;
    localparam int          PMI_BUS_MSB     = 15;

    // arithmetic divisors
    localparam int          PMI_CUR_DIV     = 2048;
    localparam int          PMI_PWR_DIV     = 20000;

    // timing
    localparam int unsigned PMI_CLK_HZ      = 100_000_000;
    localparam int unsigned PMI_TOUT_MS     = 28;
    localparam int unsigned PMI_TOUT_CYCLES = (PMI_CLK_HZ / 1000) * PMI_TOUT_MS;

    // result bundle handed from the arithmetic to the slave
    typedef struct packed {
        logic [15:0] shunt;
        logic [15:0] bus;
        logic [15:0] power;
        logic [15:0] current;
    } pmi_results_t;

    typedef enum logic [2:0] {
        PMI_IDLE,
        PMI_ADDR,
        PMI_ADDR_ACK,
        PMI_RX,
        PMI_RX_ACK,
        PMI_TX,
        PMI_TX_ACK
    } pmi_state_t;

endpackage : pmi_pkg

// ---- src/pmi_calc.sv ----
// pmi_calc: registered result arithmetic for current, bus voltage, power.
// assumes raw converter codes arrive on clk_in and calibration is stable.
`timescale 1ns/1ps
module pmi_calc
    import pmi_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [15:0]  shunt_code_in,
    input  wire logic [15:0]  bus_code_in,
    input  wire logic [15:0]  cal_in,
    output pmi_results_t      results_out
);

    pmi_results_t res_ff;
    pmi_results_t nxt_res;

    // signed division that keeps only the integer part
    function automatic logic signed [33:0] div_trunc(
        input logic signed [33:0] num,
        input logic signed [33:0] den
    );
        div_trunc = num / den;
    endfunction : div_trunc

    // next results, recomputed every cycle
    always_comb begin
        logic signed [33:0] cur_prod;
        logic signed [33:0] cur_mag;
        logic signed [33:0] pwr_prod;
        cur_prod = 34'sd0;
        cur_mag  = 34'sd0;
        pwr_prod = 34'sd0;
        nxt_res  = res_ff;
        nxt_res.shunt = shunt_code_in;
        nxt_res.bus   = {1'b0, bus_code_in[PMI_BUS_MSB-1:0]};
        cur_prod = 34'(signed'(shunt_code_in)) * 34'(signed'({1'b0, cal_in}));
        nxt_res.current = 16'(div_trunc(cur_prod, 34'(PMI_CUR_DIV)));
        // magnitude of current times bus code; the 20000 divisor
        // carries the fixed 25-step power weight
        cur_mag  = res_ff.current[15] ? -34'(signed'(res_ff.current))
                                      : 34'(signed'(res_ff.current));
        pwr_prod = cur_mag * 34'(signed'({1'b0, res_ff.bus}));
        nxt_res.power = 16'(div_trunc(pwr_prod, 34'(PMI_PWR_DIV)));
        if (cal_in == PMI_ZERO16) begin
            nxt_res.current = PMI_ZERO16;
            nxt_res.power   = PMI_ZERO16;
        end
    end

    // result registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            res_ff <= '0;
        end else begin
            res_ff <= nxt_res;
        end
    end

    assign results_out = res_ff;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_cal_zero_gate: assert property (
        cal_in == PMI_ZERO16 |=> res_ff.current == PMI_ZERO16
                                 && res_ff.power == PMI_ZERO16)
        else $error("current or power nonzero without calibration");

    a_bus_msb_zero: assert property (
        ##1 !res_ff.bus[PMI_BUS_MSB])
        else $error("bus result msb set");

    a_bus_fixed_weight: assert property (
        1'b1 |=> res_ff.bus[14:0] == $past(bus_code_in[14:0]))
        else $error("bus result not the raw 1.25 mV code");

    a_current_scale: assert property (
        (!shunt_code_in[15] && cal_in != PMI_ZERO16)
        |=> res_ff.current ==
            16'((32'($past(shunt_code_in)) * 32'($past(cal_in))) >> 11))
        else $error("current result not shunt*cal/2048");

    c_cal_loaded: cover property (
        cal_in != PMI_ZERO16 ##2 res_ff.power != PMI_ZERO16);

endmodule : pmi_calc

// ---- src/pmi_i2c_slave.sv ----
// pmi_i2c_slave: two-wire slave front end with pointer and register file.
// assumes scl, sda and strap codes arrive asynchronously from pins and the
// converter codes arrive on clk_in; the bus pads resolve the enables.
`timescale 1ns/1ps
module pmi_i2c_slave
    import pmi_pkg::*;
#(
    parameter int unsigned TOUT_CYCLES = PMI_TOUT_CYCLES
)(
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic         scl_in,
    input  wire logic         sda_in,
    output logic              sda_out,
    output logic              sda_oe_n_out,
    output logic              scl_out,
    output logic              scl_oe_n_out,
    input  wire logic [1:0]   addr_strap_low_in,
    input  wire logic [1:0]   addr_strap_high_in,
    input  wire logic [15:0]  shunt_code_in,
    input  wire logic [15:0]  bus_code_in,
    output logic [15:0]       config_out
);

    localparam int TW = $clog2(TOUT_CYCLES + 1);

    // pin synchronisers, third stage only for edge detection
    logic        scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic        sda_s1_ff, sda_s2_ff, sda_d_ff;
    logic [1:0]  strap_lo_s1_ff, strap_lo_s2_ff;
    logic [1:0]  strap_hi_s1_ff, strap_hi_s2_ff;

    // protocol state
    pmi_state_t  state_ff, nxt_state;
    logic [3:0]  bit_cnt_ff, nxt_bit_cnt;
    logic [7:0]  shift_ff, nxt_shift;
    logic [1:0]  byte_idx_ff, nxt_byte_idx;
    logic        rw_ff, nxt_rw;
    logic        tx_low_ff, nxt_tx_low;
    logic        nack_ff, nxt_nack;
    logic        sda_oe_n_ff, nxt_sda_oe_n;
    logic [6:0]  addr_ff, nxt_addr;

    // register file
    logic [7:0]  ptr_ff, nxt_ptr;
    logic [7:0]  hold_hi_ff, nxt_hold_hi;
    logic [15:0] cfg_ff, nxt_cfg;
    logic [15:0] cal_ff, nxt_cal;

    // timeout
    logic [TW-1:0] tout_cnt_ff, nxt_tout_cnt;

    logic         scl_rise, scl_fall, start_det, stop_det, tout_hit, quiet;
    logic [15:0]  rd_word;
    pmi_results_t results;

    // read decode; unmapped pointers read zero
    function automatic logic [15:0] read_reg(
        input logic [7:0]   ptr,
        input logic [15:0]  cfg,
        input logic [15:0]  cal,
        input pmi_results_t r
    );
        unique case (ptr)
            PMI_REG_CONFIG:  read_reg = cfg;
            PMI_REG_SHUNT:   read_reg = r.shunt;
            PMI_REG_BUS:     read_reg = r.bus;
            PMI_REG_POWER:   read_reg = r.power;
            PMI_REG_CURRENT: read_reg = r.current;
            PMI_REG_CAL:     read_reg = cal;
            default:         read_reg = PMI_ZERO16;
        endcase
    endfunction : read_reg

    pmi_calc u_calc (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .shunt_code_in (shunt_code_in),
        .bus_code_in   (bus_code_in),
        .cal_in        (cal_ff),
        .results_out   (results)
    );

    // two flops before any logic looks at a pin
    // fast sampling follows bus clocks up to 2.94 MHz
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            scl_s1_ff      <= 1'b1;
            scl_s2_ff      <= 1'b1;
            scl_d_ff       <= 1'b1;
            sda_s1_ff      <= 1'b1;
            sda_s2_ff      <= 1'b1;
            sda_d_ff       <= 1'b1;
            strap_lo_s1_ff <= 2'h0;
            strap_lo_s2_ff <= 2'h0;
            strap_hi_s1_ff <= 2'h0;
            strap_hi_s2_ff <= 2'h0;
        end else begin
            scl_s1_ff      <= scl_in;
            scl_s2_ff      <= scl_s1_ff;
            scl_d_ff       <= scl_s2_ff;
            sda_s1_ff      <= sda_in;
            sda_s2_ff      <= sda_s1_ff;
            sda_d_ff       <= sda_s2_ff;
            strap_lo_s1_ff <= addr_strap_low_in;
            strap_lo_s2_ff <= strap_lo_s1_ff;
            strap_hi_s1_ff <= addr_strap_high_in;
            strap_hi_s2_ff <= strap_hi_s1_ff;
        end
    end

    // edges and framing
    assign scl_rise  = scl_s2_ff && !scl_d_ff;
    assign scl_fall  = !scl_s2_ff && scl_d_ff;
    assign start_det = scl_s2_ff && scl_d_ff && sda_d_ff && !sda_s2_ff;
    assign stop_det  = scl_s2_ff && scl_d_ff && !sda_d_ff && sda_s2_ff;
    assign tout_hit  = tout_cnt_ff == TW'(TOUT_CYCLES - 1);
    assign quiet     = !stop_det && !start_det && !tout_hit;
    assign rd_word   = read_reg(ptr_ff, cfg_ff, cal_ff, results);

    // stall timer, restarted by any clock edge or framing
    always_comb begin
        nxt_tout_cnt = tout_cnt_ff + TW'(1);
        if (state_ff == PMI_IDLE || scl_rise || scl_fall || start_det
                || tout_hit) begin
            nxt_tout_cnt = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tout_cnt_ff <= '0;
        end else begin
            tout_cnt_ff <= nxt_tout_cnt;
        end
    end

    // protocol engine; sda_oe_n low pulls the line low, high releases it
    always_comb begin
        nxt_state    = state_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_shift    = shift_ff;
        nxt_byte_idx = byte_idx_ff;
        nxt_rw       = rw_ff;
        nxt_tx_low   = tx_low_ff;
        nxt_nack     = nack_ff;
        nxt_sda_oe_n = sda_oe_n_ff;
        nxt_addr     = addr_ff;
        nxt_ptr      = ptr_ff;
        nxt_hold_hi  = hold_hi_ff;
        nxt_cfg      = cfg_ff;
        nxt_cal      = cal_ff;
        if (stop_det) begin
            nxt_state    = PMI_IDLE;
            nxt_sda_oe_n = 1'b1;
        end else if (start_det) begin
            // straps taken at every start, also repeated ones
            // fixed three bits, then high and low strap codes
            nxt_addr     = {PMI_ADDR_FIXED[2:0], strap_hi_s2_ff,
                            strap_lo_s2_ff};
            nxt_state    = PMI_ADDR;
            nxt_bit_cnt  = 4'h0;
            nxt_byte_idx = 2'h0;
            nxt_sda_oe_n = 1'b1;
        end else if (tout_hit && state_ff != PMI_IDLE) begin
            nxt_state    = PMI_IDLE;
            nxt_sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            // bits shifted in on rising clock
            if ((state_ff == PMI_ADDR || state_ff == PMI_RX)
                    && bit_cnt_ff != PMI_BYTE_BITS) begin
                nxt_shift   = {shift_ff[6:0], sda_s2_ff};
                nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end else if (state_ff == PMI_TX_ACK) begin
                nxt_nack = sda_s2_ff;
            end
        end else if (scl_fall) begin
            unique case (state_ff)
                PMI_IDLE: begin
                end
                PMI_ADDR: begin
                    // eighth bit is direction, ack on ninth clock
                    if (bit_cnt_ff == PMI_BYTE_BITS) begin
                        if (shift_ff[7:1] == addr_ff) begin
                            nxt_rw       = shift_ff[0];
                            nxt_sda_oe_n = 1'b0;
                            nxt_state    = PMI_ADDR_ACK;
                        end else begin
                            nxt_state = PMI_IDLE;
                        end
                    end
                end
                PMI_ADDR_ACK: begin
                    nxt_bit_cnt = 4'h0;
                    if (rw_ff) begin
                        // high byte of the pointed register first
                        nxt_shift    = rd_word[15:8];
                        nxt_sda_oe_n = rd_word[15];
                        nxt_tx_low   = 1'b1;
                        nxt_bit_cnt  = 4'h1;
                        nxt_state    = PMI_TX;
                    end else begin
                        nxt_sda_oe_n = 1'b1;
                        nxt_state    = PMI_RX;
                    end
                end
                PMI_RX: begin
                    if (bit_cnt_ff == PMI_BYTE_BITS) begin
                        nxt_sda_oe_n = 1'b0;
                        nxt_state    = PMI_RX_ACK;
                        if (byte_idx_ff != 2'h3) begin
                            nxt_byte_idx = byte_idx_ff + 2'h1;
                        end
                        unique case (byte_idx_ff)
                            // pointer alone is a complete write
                            2'h0: nxt_ptr = shift_ff;
                            // high byte held until the low byte
                            2'h1: nxt_hold_hi = shift_ff;
                            2'h2: begin
                                // word lands in the pointed register if config or calibration, else dropped
                                if (ptr_ff == PMI_REG_CONFIG) begin
                                    nxt_cfg = {hold_hi_ff, shift_ff};
                                end
                                if (ptr_ff == PMI_REG_CAL) begin
                                    nxt_cal = {hold_hi_ff, shift_ff};
                                end
                            end
                            2'h3: begin
                            end
                        endcase
                    end
                end
                PMI_RX_ACK: begin
                    nxt_sda_oe_n = 1'b1;
                    nxt_bit_cnt  = 4'h0;
                    nxt_state    = PMI_RX;
                end
                PMI_TX: begin
                    if (bit_cnt_ff == PMI_BYTE_BITS) begin
                        nxt_sda_oe_n = 1'b1;
                        nxt_nack     = 1'b1;
                        nxt_state    = PMI_TX_ACK;
                    end else begin
                        nxt_shift    = {shift_ff[6:0], 1'b0};
                        nxt_sda_oe_n = shift_ff[6];
                        nxt_bit_cnt  = bit_cnt_ff + 4'h1;
                    end
                end
                PMI_TX_ACK: begin
                    if (nack_ff) begin
                        nxt_state = PMI_IDLE;
                    end else begin
                        nxt_shift    = tx_low_ff ? rd_word[7:0]
                                                 : rd_word[15:8];
                        nxt_sda_oe_n = tx_low_ff ? rd_word[7]
                                                 : rd_word[15];
                        nxt_tx_low   = !tx_low_ff;
                        nxt_bit_cnt  = 4'h1;
                        nxt_state    = PMI_TX;
                    end
                end
            endcase
        end
    end

    // protocol and register state; contents are volatile
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_ff    <= PMI_IDLE;
            bit_cnt_ff  <= 4'h0;
            shift_ff    <= 8'h00;
            byte_idx_ff <= 2'h0;
            rw_ff       <= 1'b0;
            tx_low_ff   <= 1'b0;
            nack_ff     <= 1'b1;
            sda_oe_n_ff <= 1'b1;
            addr_ff     <= 7'h00;
            ptr_ff      <= PMI_REG_CONFIG;
            hold_hi_ff  <= 8'h00;
            cfg_ff      <= PMI_CFG_RESET;
            cal_ff      <= PMI_ZERO16;
        end else begin
            state_ff    <= nxt_state;
            bit_cnt_ff  <= nxt_bit_cnt;
            shift_ff    <= nxt_shift;
            byte_idx_ff <= nxt_byte_idx;
            rw_ff       <= nxt_rw;
            tx_low_ff   <= nxt_tx_low;
            nack_ff     <= nxt_nack;
            sda_oe_n_ff <= nxt_sda_oe_n;
            addr_ff     <= nxt_addr;
            ptr_ff      <= nxt_ptr;
            hold_hi_ff  <= nxt_hold_hi;
            cfg_ff      <= nxt_cfg;
            cal_ff      <= nxt_cal;
        end
    end

    // open-drain data only; the clock pin is never driven
    assign sda_out      = 1'b0;
    assign scl_out      = 1'b0;
    assign scl_oe_n_out = 1'b1;
    assign sda_oe_n_out = sda_oe_n_ff;
    assign config_out   = cfg_ff;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_slave_only_pins: assert property (
        scl_oe_n_out && !sda_out && !scl_out)
        else $error("slave drives clock or high level");

    a_stop_releases: assert property (
        stop_det |=> state_ff == PMI_IDLE && sda_oe_n_out)
        else $error("stop did not release the bus");

    a_addr_ack_drive: assert property (
        (quiet && scl_fall && state_ff == PMI_ADDR
         && bit_cnt_ff == PMI_BYTE_BITS && shift_ff[7:1] == addr_ff)
        |=> !sda_oe_n_out && state_ff == PMI_ADDR_ACK
            ##1 rw_ff == $past(shift_ff[0], 2))
        else $error("matching address not acknowledged");

    a_strap_address: assert property (
        (start_det && !stop_det) |=> addr_ff ==
            {PMI_ADDR_FIXED[2:0], $past(strap_hi_s2_ff),
             $past(strap_lo_s2_ff)})
        else $error("slave address not built from straps");

    a_timeout_idle: assert property (
        (tout_hit && !stop_det && !start_det && state_ff != PMI_IDLE)
        |=> state_ff == PMI_IDLE && sda_oe_n_out)
        else $error("stalled transaction not abandoned");

    a_ptr_kept_read: assert property (
        (rw_ff && (state_ff == PMI_TX || state_ff == PMI_TX_ACK))
        |=> $stable(ptr_ff))
        else $error("pointer changed during a read");

    a_write_loads: assert property (
        (quiet && scl_fall && state_ff == PMI_RX && ptr_ff == PMI_REG_CAL
         && bit_cnt_ff == PMI_BYTE_BITS && byte_idx_ff == 2'h2)
        |=> cal_ff == {$past(hold_hi_ff), $past(shift_ff)}
            && !sda_oe_n_out)
        else $error("calibration write not loaded");

    a_ptr_only: assert property (
        (quiet && scl_fall && state_ff == PMI_RX
         && bit_cnt_ff == PMI_BYTE_BITS && byte_idx_ff == 2'h0)
        |=> ptr_ff == $past(shift_ff) && $stable(cfg_ff) && $stable(cal_ff))
        else $error("pointer byte mishandled");

    a_high_byte_first: assert property (
        (quiet && scl_fall && state_ff == PMI_ADDR_ACK && rw_ff)
        |=> shift_ff == $past(rd_word[15:8])
            && sda_oe_n_out == $past(rd_word[15]))
        else $error("read did not start with the high byte");

    c_write_word: cover property (
        state_ff == PMI_RX && byte_idx_ff == 2'h3 ##1 stop_det);
    c_read_two: cover property (
        state_ff == PMI_TX_ACK && !tx_low_ff ##1 state_ff == PMI_TX);
    c_timeout: cover property (tout_hit && state_ff != PMI_IDLE);
    c_nack_end: cover property (
        state_ff == PMI_TX_ACK && nack_ff && scl_fall);

endmodule : pmi_i2c_slave

// ---- sim/pmi_master.sv ----
// pmi_master: two-wire bus master model for the monitor slave.
// assumes pull-ups on both lines; the bench resolves the wire levels.
`timescale 1ns/1ps
module pmi_master (
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    logic [6:0] dev_addr = 7'h40;
    // idle: both lines released
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // one bit cell, 125 ns period, data moved only while clock low
    task automatic bit_cell(input logic v, output logic s);
        #31.25 sda_out = v;
        #31.25 scl_out = 1'b1;
        #31.25 s = sda_in;
        #31.25 scl_out = 1'b0;
    endtask : bit_cell
    // start or stop framing, edges only while clock high
    task automatic frame(input logic stop);
        #31.25 sda_out = !stop;
        #31.25 scl_out = 1'b1;
        #31.25 sda_out = stop;
        #31.25 scl_out = stop;
    endtask : frame
    // byte msb first, then ack cell (a=1 releases or nacks)
    task automatic xfer(input logic [7:0] b, input logic a,
                        output logic [7:0] d, output logic k);
        for (int i = 7; i >= 0; i--) bit_cell(b[i], d[i]);
        bit_cell(a, k);
    endtask : xfer
    // address, pointer, then a two-byte word if n > 0; ok if address and pointer acked
    task automatic wr(input logic [7:0] p, input logic [15:0] w,
                      input int n, output logic ok);
        logic [7:0] d;
        logic       k;
        frame(1'b0);
        xfer({dev_addr, 1'b0}, 1'b1, d, k);
        ok = !k;
        xfer(p, 1'b1, d, k);
        ok = ok & !k;
        if (n > 0) begin
            xfer(w[15:8], 1'b1, d, k);
            xfer(w[7:0], 1'b1, d, k);
        end
        frame(1'b1);
    endtask : wr
    // read word: ack high byte, nack low byte, stop
    task automatic rd(output logic [15:0] w);
        logic [7:0] d;
        logic       k;
        frame(1'b0);
        xfer({dev_addr, 1'b1}, 1'b1, d, k);
        xfer(8'hFF, 1'b0, w[15:8], k);
        xfer(8'hFF, 1'b1, w[7:0], k);
        frame(1'b1);
    endtask : rd
endmodule : pmi_master

// ---- sim/test_power_monitor_i2c_slave.sv ----
// test_power_monitor_i2c_slave: self-checking bench of the serial slave.
// assumes pmi_master as bus partner and pull-ups on both lines.
`timescale 1ns/1ps
module test_power_monitor_i2c_slave;
    import pmi_pkg::*;
    localparam int unsigned TOUT = 200; // short timeout keeps the run brief
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [3:0]  strap = 4'h0;
    logic [15:0] shunt = 16'h0000, bus = 16'h0000, w, cal, cfg;
    logic [31:0] lfsr = 32'h568B;
    logic [7:0]  d;
    logic        ok, k, scl_m, sda_m, sda_d, sda_oe_n, scl_d, scl_oe_n;
    int          err_total = 0, compares = 0, cyc = 0;
    // wired-and of both parties on each line
    wire sda_w = sda_m & (sda_oe_n | sda_d);
    wire scl_w = scl_m & (scl_oe_n | scl_d);
    pmi_master m (.sda_in(sda_w), .scl_out(scl_m), .sda_out(sda_m));
    pmi_i2c_slave #(.TOUT_CYCLES(TOUT)) dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_w),
        .sda_in(sda_w), .sda_out(sda_d), .sda_oe_n_out(sda_oe_n),
        .scl_out(scl_d), .scl_oe_n_out(scl_oe_n),
        .addr_strap_low_in(strap[1:0]), .addr_strap_high_in(strap[3:2]),
        .shunt_code_in(shunt), .bus_code_in(bus), .config_out(cfg));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // pointer-only write, then a word read compared with exp
    task automatic chk_reg(input logic [7:0] p, input logic [15:0] exp);
        logic [15:0] v;
        m.wr(p, 16'h0000, 0, ok);
        m.rd(v);
        check(v, exp);
    endtask : chk_reg
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    function automatic logic [15:0] exp_cur(input logic [15:0] s, c);
        if (c == 16'h0000) return 16'h0000;
        return 16'($signed(s) * int'(c) / PMI_CUR_DIV);
    endfunction : exp_cur
    function automatic logic [15:0] exp_pwr(input logic [15:0] cr, b);
        int a;
        a = $signed(cr);
        if (a < 0) a = -a;
        return 16'(a * int'(b & 16'h7FFF) / PMI_PWR_DIV);
    endfunction : exp_pwr
    // 100 MHz clock
    initial forever #5 clk_in = ~clk_in;
    // watchdog: a hang counts as a mismatch
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 80000) begin
            err_total++;
            finish_test();
        end
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clk_in);
        #1 sys_rst_in = 1'b0;
        repeat (5) @(posedge clk_in);
        // every strap code, own address and a foreign one
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_in) #1 strap = 4'(i);
            m.dev_addr = 7'h40 | 7'(i);
            m.wr(PMI_REG_CONFIG, 16'h0000, 0, ok);
            check({15'h0, ok}, 16'h0001);
            m.dev_addr = 7'h40 | 7'(i ^ 1);
            m.wr(PMI_REG_CONFIG, 16'h0000, 0, ok);
            check({15'h0, ok}, 16'h0000);
        end
        m.dev_addr = 7'h4F;
        @(posedge clk_in) #1 {shunt, bus} = lfsr;
        chk_reg(PMI_REG_CONFIG, PMI_CFG_RESET);
        chk_reg(PMI_REG_SHUNT, shunt);
        chk_reg(PMI_REG_BUS, bus & 16'h7FFF);
        chk_reg(PMI_REG_CURRENT, 16'h0000);
        chk_reg(PMI_REG_POWER, 16'h0000);
        // worked example first, then random codes and calibration
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            cal = i == 0 ? 16'h0A00 : (lfsr[15:0] & 16'h3FFF) | 16'h0001;
            @(posedge clk_in) #1 bus = i == 0 ? 16'h2570 : lfsr[31:16];
            shunt = i == 0 ? 16'h1F40 : {{5{lfsr[26]}}, lfsr[26:16]};
            m.wr(PMI_REG_CAL, cal, 2, ok);
            m.wr(PMI_REG_POWER, ~cal, 2, ok);
            m.wr(PMI_REG_CONFIG, lfsr[15:0], 2, ok);
            check(cfg, lfsr[15:0]);
            chk_reg(PMI_REG_CAL, cal);
            chk_reg(PMI_REG_BUS, bus & 16'h7FFF);
            chk_reg(PMI_REG_CURRENT, exp_cur(shunt, cal));
            chk_reg(PMI_REG_POWER, exp_pwr(exp_cur(shunt, cal), bus));
            m.rd(w);
            check(w, exp_pwr(exp_cur(shunt, cal), bus));
        end
        // stall mid read while the device pulls its first data bit low
        chk_reg(PMI_REG_CAL, cal);
        m.frame(1'b0);
        m.xfer({m.dev_addr, 1'b1}, 1'b1, d, k);
        repeat (10) @(posedge clk_in);
        #1 check({15'h0, sda_oe_n}, 16'h0000);
        repeat (TOUT + 20) @(posedge clk_in);
        #1 check({15'h0, sda_oe_n}, 16'h0001);
        m.frame(1'b1);
        chk_reg(PMI_REG_CAL, cal);
        finish_test();
    end
endmodule : test_power_monitor_i2c_slave
